// ===== fpc_pkg.sv
// Package: constants, register map and types of the fast pulse counter unit
// Functional notes
// - Four inputs, each assignable to any function
// - Two counters, each in one mode
// - Two- or four-counter build, fixed at build
// - Four-counter build drops quadrature, one stepper
// - Some modes use two inputs
// - Counter result always readable by program
// - Clear zeroes accumulator; not in frequency/period
// - Disable blocks counting and result loads, not clear, preload or marker
// - Latch captures on strobe start or end
// - Preload loads value; not in frequency/period
// - Trigger polarity: high, low, falling, rising
// - Marker input resets position reference
// - Frequency in hertz over four windows
// - Quadrature counts every edge, direction by lead
package fpc_pkg;
  localparam bit FOUR_BUILD = 1'b0;
  localparam int NUM_CTR = FOUR_BUILD ? 4 : 2;
  localparam int NUM_IN = 4;
  localparam int NUM_FN = 4;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int US_PS = 1000000;
  localparam int US_CYC = (US_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int US_W = $clog2(US_CYC);
  localparam logic [US_W-1:0] US_LAST = US_W'(US_CYC - 1);
  localparam longint FREQ_WIN_PS = 64'h0000_00E8_D4A5_1000;
  localparam int unsigned FREQ_WIN_DEF = 32'(FREQ_WIN_PS / CLK_PERIOD_PS);
  localparam logic [1:0] STEP_OUTS = FOUR_BUILD ? 2'h1 : 2'h2;
  localparam logic [AW-1:0] ADDR_CAP = 8'h00;
  localparam logic [AW-1:0] CTR_BASE = 8'h10;
  localparam logic [AW-1:0] CTR_STRIDE = 8'h20;
  localparam logic [AW-1:0] OFS_CFG = 8'h00;
  localparam logic [AW-1:0] OFS_SPF = 8'h04;
  localparam logic [AW-1:0] OFS_PRE = 8'h08;
  localparam logic [AW-1:0] OFS_ACC = 8'h0C;
  localparam logic [AW-1:0] OFS_LAT = 8'h10;
  localparam logic [DW-1:0] CFG_MASK = 32'h0000_7FFF;
  localparam logic [DW-1:0] SPF_MASK = 32'h3F3F_3F3F;
  localparam logic [1:0] T_UP = 2'h0;
  localparam logic [1:0] T_DOWN = 2'h1;
  localparam logic [1:0] T_UPDN = 2'h2;
  localparam logic [1:0] T_CLKDIR = 2'h3;
  localparam logic [1:0] POL_HIGH = 2'h0;
  localparam logic [1:0] POL_LOW = 2'h1;
  localparam logic [1:0] POL_FALL = 2'h2;
  localparam logic [1:0] POL_RISE = 2'h3;
  localparam int SUB_ALT = 0;
  localparam int FN_CLR = 0;
  localparam int FN_DIS = 1;
  localparam int FN_LAT = 2;
  localparam int FN_PRE = 3;
  typedef enum logic [2:0] {M_TOTAL, M_FREQ, M_PWIDTH, M_PERIOD, M_QUAD}
    fpc_mode_e;
  typedef struct packed {
    logic [16:0] rsv;
    logic [1:0] mrk_src;
    logic mrk_en;
    logic [1:0] win;
    logic b_en;
    logic [1:0] in_b;
    logic [1:0] in_a;
    logic [1:0] sub;
    logic [2:0] mode;
  } fpc_cfg_s;
  typedef struct packed {
    logic [1:0] rsv;
    logic late;
    logic [1:0] pol;
    logic [1:0] src;
    logic en;
  } fpc_fn_s;
  typedef fpc_fn_s [NUM_FN-1:0] fpc_spf_t;
  typedef struct packed {
    logic [17:0] rsv;
    logic [1:0] steps;
    logic quad_ok;
    logic [2:0] num_ctr;
    logic [NUM_IN-1:0] lvl;
    logic [NUM_IN-1:0] in_use;
  } fpc_cap_s;
endpackage

// ===== fpc_pin_if.sv
// Interface: synchronised field input levels and edge pulses
`timescale 1ns/1ps
`default_nettype none
interface fpc_pin_if import fpc_pkg::*; ();
  logic [NUM_IN-1:0] lvl;
  logic [NUM_IN-1:0] rise;
  logic [NUM_IN-1:0] fall;
  modport src (output lvl, rise, fall);
  modport dst (input lvl, rise, fall);
endinterface
`default_nettype wire

// ===== fpc_sync.sv
// Field input synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module fpc_sync import fpc_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic [NUM_IN-1:0] pin,
  fpc_pin_if.src o
);
  typedef struct packed {
    logic [NUM_IN-1:0] s1;
    logic [NUM_IN-1:0] s2;
    logic [NUM_IN-1:0] s3;
    logic [NUM_IN-1:0] lvl;
    logic [NUM_IN-1:0] rise;
    logic [NUM_IN-1:0] fall;
  } fpc_sync_s;

  fpc_sync_s q, next_q;
  logic [NUM_IN-1:0] agree;

  // s1 feeds s2 only; decisions are taken on s2 and s3
  always_comb begin
    next_q = q;
    agree = ~(q.s2 ^ q.s3);
    next_q.s1 = pin;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    next_q.lvl = (q.s2 & agree) | (q.lvl & ~agree);
    next_q.rise = agree & q.s2 & ~q.lvl;
    next_q.fall = agree & ~q.s2 & q.lvl;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign o.lvl = q.lvl;
  assign o.rise = q.rise;
  assign o.fall = q.fall;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_sync_edge: assert property (
    q.rise == (q.lvl & ~$past(q.lvl)))
    else $error("rise pulse does not match level change");
  a_sync_agree: assert property (
    ((q.lvl ^ $past(q.lvl)) & $past(q.s2 ^ q.s3)) == '0)
    else $error("level changed without stage agreement");
endmodule // fpc_sync
`default_nettype wire

// ===== fpc_top.sv
// Fast pulse counter unit: register port, counters, modes, special functions
`timescale 1ns/1ps
`default_nettype none
module fpc_top import fpc_pkg::*; #(
  parameter int unsigned FREQ_WIN_CYC = FREQ_WIN_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [NUM_IN-1:0] pin,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DW-1:0] rdata
);
  typedef struct packed {
    logic [DW-1:0] acc;
    logic [DW-1:0] lat;
    logic [DW-1:0] meas;
    logic [DW-1:0] win;
    logic armed;
  } fpc_ctr_s;

  typedef struct packed {
    fpc_ctr_s [NUM_CTR-1:0] c;
    fpc_cfg_s [NUM_CTR-1:0] cfg;
    fpc_spf_t [NUM_CTR-1:0] spf;
    logic [NUM_CTR-1:0][DW-1:0] pre;
    logic [US_W-1:0] us_cnt;
    logic [DW-1:0] rdata;
  } fpc_top_s;

  localparam logic [AW-1:0] ACC0_ADDR = CTR_BASE + OFS_ACC;

  fpc_top_s q, next_q;
  logic us_tick;
  logic [NUM_CTR-1:0] clr_f;
  logic [NUM_CTR-1:0] pre_f;
  logic [NUM_CTR-1:0] lat_f;
  logic [NUM_CTR-1:0] dis_a;
  logic [NUM_CTR-1:0] mrk_f;
  logic [NUM_CTR-1:0] inc;
  logic [NUM_CTR-1:0] dec;
  logic [NUM_IN-1:0] in_use;

  fpc_pin_if pins ();

  fpc_sync u_sync (
    .clk(clk),
    .srst(srst),
    .pin(pin),
    .o(pins)
  );

  always_comb begin
    fpc_cfg_s c;
    fpc_fn_s f;
    fpc_mode_e m;
    logic [NUM_FN-1:0] act;
    logic [NUM_FN-1:0] st;
    logic [NUM_FN-1:0] sp;
    logic [NUM_FN-1:0] edg;
    logic hi;
    logic ar;
    logic af;
    logic al;
    logic br;
    logic bf;
    logic bl;
    logic up;
    logic lv;
    logic e_start;
    logic e_end;
    logic legal;
    logic b_used;
    logic res_v;
    logic [DW-1:0] res;
    logic [DW-1:0] cnt;
    logic [DW-1:0] span;
    logic [AW-1:0] base;
    c = '0;
    f = '0;
    m = M_TOTAL;
    act = '0;
    st = '0;
    sp = '0;
    edg = '0;
    hi = 1'b0;
    ar = 1'b0;
    af = 1'b0;
    al = 1'b0;
    br = 1'b0;
    bf = 1'b0;
    bl = 1'b0;
    up = 1'b0;
    lv = 1'b0;
    e_start = 1'b0;
    e_end = 1'b0;
    legal = 1'b0;
    b_used = 1'b0;
    res_v = 1'b0;
    res = '0;
    cnt = '0;
    span = '0;
    base = '0;
    next_q = q;
    next_q.rdata = '0;
    clr_f = '0;
    pre_f = '0;
    lat_f = '0;
    dis_a = '0;
    mrk_f = '0;
    inc = '0;
    dec = '0;
    in_use = '0;
    // One shared microsecond strobe paces width and period counts
    us_tick = (q.us_cnt == US_LAST);
    next_q.us_cnt = us_tick ? '0 : q.us_cnt + US_W'(1);

    for (int i = 0; i < NUM_CTR; i++) begin
      c = q.cfg[i];
      m = fpc_mode_e'(c.mode);
      base = CTR_BASE + AW'(i) * CTR_STRIDE;
      res_v = 1'b0;
      res = '0;
      b_used = 1'b0;
      legal = 1'b1;

      // Special function triggers may come from any field input
      for (int k = 0; k < NUM_FN; k++) begin
        f = q.spf[i][k];
        hi = (f.pol == POL_HIGH) || (f.pol == POL_RISE);
        edg[k] = (f.pol == POL_FALL) || (f.pol == POL_RISE);
        act[k] = f.en && (pins.lvl[f.src] == hi);
        st[k] = f.en && (hi ? pins.rise[f.src] : pins.fall[f.src]);
        sp[k] = f.en && (hi ? pins.fall[f.src] : pins.rise[f.src]);
      end
      clr_f[i] = !(m inside {M_FREQ, M_PERIOD})
        && (edg[FN_CLR] ? st[FN_CLR] : act[FN_CLR]);
      pre_f[i] = !(m inside {M_FREQ, M_PERIOD})
        && (edg[FN_PRE] ? st[FN_PRE] : act[FN_PRE]);
      // Edge polarities still freeze on the level, not a single cycle
      dis_a[i] = act[FN_DIS];
      lat_f[i] = q.spf[i][FN_LAT].late ? sp[FN_LAT] : st[FN_LAT];

      ar = pins.rise[c.in_a];
      af = pins.fall[c.in_a];
      al = pins.lvl[c.in_a];
      br = pins.rise[c.in_b];
      bf = pins.fall[c.in_b];
      bl = pins.lvl[c.in_b];

      unique case (m)
        M_TOTAL: begin
          b_used = c.b_en || (c.sub == T_UPDN) || (c.sub == T_CLKDIR);
          unique case (c.sub)
            T_UP: inc[i] = ar || (c.b_en && br);
            T_DOWN: dec[i] = ar || (c.b_en && br);
            T_UPDN: begin
              inc[i] = ar;
              dec[i] = br;
            end
            T_CLKDIR: begin
              inc[i] = ar && !bl;
              dec[i] = ar && bl;
            end
          endcase
        end
        M_QUAD: begin
          // Relies on the encoder keeping its two phases a quarter apart
          legal = !FOUR_BUILD;
          b_used = 1'b1;
          up = (ar && !bl) || (al && br) || (af && bl) || (!al && bf);
          if (legal && (ar || af || br || bf)) begin
            inc[i] = up ^ c.sub[SUB_ALT];
            dec[i] = !(up ^ c.sub[SUB_ALT]);
          end
          mrk_f[i] = legal && c.mrk_en && pins.rise[c.mrk_src];
        end
        M_FREQ: begin
          span = DW'(FREQ_WIN_CYC >> c.win);
          cnt = q.c[i].meas + DW'(ar);
          if (q.c[i].win == '0) begin
            // Window halves per step, so the count scales to hertz by shift
            res_v = q.c[i].armed;
            res = cnt << c.win;
            next_q.c[i].armed = 1'b1;
            next_q.c[i].meas = '0;
            next_q.c[i].win = span - 32'h1;
          end else begin
            next_q.c[i].win = q.c[i].win - 32'h1;
            next_q.c[i].meas = cnt;
          end
        end
        M_PWIDTH: begin
          lv = al ^ c.sub[SUB_ALT];
          e_start = c.sub[SUB_ALT] ? af : ar;
          e_end = c.sub[SUB_ALT] ? ar : af;
          if (e_end && q.c[i].armed) begin
            res_v = 1'b1;
            res = q.c[i].meas;
            next_q.c[i].armed = 1'b0;
          end else if (e_start) begin
            next_q.c[i].meas = '0;
            next_q.c[i].armed = 1'b1;
          end else if (q.c[i].armed && lv && us_tick) begin
            next_q.c[i].meas = q.c[i].meas + 32'h1;
          end
        end
        M_PERIOD: begin
          e_start = c.sub[SUB_ALT] ? af : ar;
          if (e_start) begin
            res_v = q.c[i].armed;
            res = q.c[i].meas;
            next_q.c[i].meas = '0;
            next_q.c[i].armed = 1'b1;
          end else if (q.c[i].armed && us_tick) begin
            next_q.c[i].meas = q.c[i].meas + 32'h1;
          end
        end
        default: legal = 1'b0;
      endcase

      // Clear beats preload beats marker; disable blocks counting and result loads
      if (clr_f[i]) begin
        next_q.c[i].acc = '0;
      end else if (pre_f[i]) begin
        next_q.c[i].acc = q.pre[i];
      end else if (mrk_f[i]) begin
        next_q.c[i].acc = '0;
      end else if (!dis_a[i]) begin
        if (res_v) begin
          next_q.c[i].acc = res;
        end else if (inc[i] && !dec[i]) begin
          next_q.c[i].acc = q.c[i].acc + 32'h1;
        end else if (dec[i] && !inc[i]) begin
          next_q.c[i].acc = q.c[i].acc - 32'h1;
        end
      end
      if (lat_f[i]) begin
        next_q.c[i].lat = q.c[i].acc;
      end

      if (legal) begin
        in_use[c.in_a] = 1'b1;
        if (b_used) begin
          in_use[c.in_b] = 1'b1;
        end
      end

      // A new mode starts its measurement from scratch
      if (wr && addr == base + OFS_CFG) begin
        next_q.cfg[i] = fpc_cfg_s'(wdata & CFG_MASK);
        next_q.c[i].meas = '0;
        next_q.c[i].win = '0;
        next_q.c[i].armed = 1'b0;
      end
      if (wr && addr == base + OFS_SPF) begin
        next_q.spf[i] = fpc_spf_t'(wdata & SPF_MASK);
      end
      if (wr && addr == base + OFS_PRE) begin
        next_q.pre[i] = wdata;
      end

      if (rd) begin
        if (addr == base + OFS_CFG) begin
          next_q.rdata = q.cfg[i];
        end else if (addr == base + OFS_SPF) begin
          next_q.rdata = q.spf[i];
        end else if (addr == base + OFS_PRE) begin
          next_q.rdata = q.pre[i];
        end else if (addr == base + OFS_ACC) begin
          next_q.rdata = q.c[i].acc;
        end else if (addr == base + OFS_LAT) begin
          next_q.rdata = q.c[i].lat;
        end
      end
    end

    if (rd && addr == ADDR_CAP) begin
      next_q.rdata = fpc_cap_s'{
        rsv: '0,
        steps: STEP_OUTS,
        quad_ok: !FOUR_BUILD,
        num_ctr: 3'(NUM_CTR),
        lvl: pins.lvl,
        in_use: in_use
      };
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rdata = q.rdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_clear_zero: assert property (
    clr_f[0] |=> q.c[0].acc == '0)
    else $error("clear did not zero counter 0");
  a_meas_noclr: assert property (
    (q.cfg[0].mode inside {M_FREQ, M_PERIOD}) |-> !clr_f[0] && !pre_f[0])
    else $error("clear or preload fired in frequency or period mode");
  a_preload_val: assert property (
    pre_f[0] && !clr_f[0] |=> q.c[0].acc == $past(q.pre[0]))
    else $error("preload value not loaded");
  a_disable_hold: assert property (
    dis_a[0] && !clr_f[0] && !pre_f[0] && !mrk_f[0]
      |=> $stable(q.c[0].acc))
    else $error("accumulator moved while disabled");
  a_latch_copy: assert property (
    lat_f[0] |=> q.c[0].lat == $past(q.c[0].acc))
    else $error("latch did not capture accumulator");
  a_latch_hold: assert property (
    !lat_f[0] |=> $stable(q.c[0].lat))
    else $error("latched value changed without strobe");
  a_count_up: assert property (
    inc[0] && !dec[0] && !dis_a[0] && !clr_f[0] && !pre_f[0] && !mrk_f[0]
      |=> q.c[0].acc == $past(q.c[0].acc) + 32'h1)
    else $error("counter did not step up by one");
  a_quad_edge: assert property (
    q.cfg[1].mode == M_QUAD && !FOUR_BUILD
      && (pins.rise[q.cfg[1].in_a] || pins.fall[q.cfg[1].in_a]
      || pins.rise[q.cfg[1].in_b] || pins.fall[q.cfg[1].in_b])
      |-> inc[1] ^ dec[1])
    else $error("quadrature edge produced no count");
  a_four_noquad: assert property (
    FOUR_BUILD && q.cfg[0].mode == M_QUAD |-> !inc[0] && !dec[0])
    else $error("quadrature counted in four-counter build");
  a_rd_acc: assert property (
    rd && addr == ACC0_ADDR |=> rdata == $past(q.c[0].acc))
    else $error("accumulator read returned wrong data");
  a_rd_quiet: assert property (
    !rd |=> rdata == '0)
    else $error("read data present without read strobe");

  c_quad_count: cover property (q.cfg[1].mode == M_QUAD && inc[1]);
  c_latch: cover property (lat_f[0] ##1 lat_f[0] == 1'b0);
  c_freq_done: cover property (q.cfg[0].mode == M_FREQ
    && q.c[0].win == '0 && q.c[0].armed);
  c_clear_level: cover property (clr_f[0] [*3]);
endmodule // fpc_top
`default_nettype wire

// ===== fpc_field_src.sv
// Field pulse source and quadrature encoder model for the counter unit
`timescale 1ns/1ps
`default_nettype none
module fpc_field_src import fpc_pkg::*; (
  input wire logic clk,
  output var logic [NUM_IN-1:0] pin
);
  initial begin
    pin = '0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Level holds at least five clocks so the synchroniser filter always agrees
  task automatic set_lvl(input int idx, input logic v);
    @(posedge clk);
    pin[idx] <= v;
    hold(4);
  endtask

  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      set_lvl(idx, 1'b1);
      set_lvl(idx, 1'b0);
    end
  endtask

  // Inputs 1 and 2 a quarter period apart; rev lets input 2 lead
  task automatic quad(input int n, input bit rev);
    logic av;
    logic bv;
    repeat (n) begin
      for (int s = 0; s < 4; s++) begin
        av = (s < 2);
        bv = (s == 1) || (s == 2);
        @(posedge clk);
        pin[1] <= rev ? bv : av;
        pin[2] <= rev ? av : bv;
        hold(3);
      end
    end
  endtask
endmodule // fpc_field_src
`default_nettype wire

// ===== tb_high_speed_counter_unit.sv
// Self-checking bench for the fast pulse counter unit
`timescale 1ns/1ps
`default_nettype none
module tb_high_speed_counter_unit import fpc_pkg::*; ;
  logic clk;
  logic srst;
  logic [NUM_IN-1:0] pin;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic wr;
  logic rd;
  logic [DW-1:0] rdata;
  logic [DW-1:0] v;
  logic [DW-1:0] cap_exp;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;

  // Short window; 60 clocks hold exactly six pulses spaced ten apart
  fpc_top #(.FREQ_WIN_CYC(60)) u_dut (
    .clk(clk),
    .srst(srst),
    .pin(pin),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata)
  );

  fpc_field_src u_src (
    .clk(clk),
    .pin(pin)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      $display("MISMATCH at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    logic [DW-1:0] d;
    rd_reg(a, d);
    check(d, exp);
  endtask

  task automatic lvl3(input logic lv);
    u_src.set_lvl(3, lv);
    wait_clk(6);
  endtask

  task automatic pulses(input int n);
    u_src.pulse(2, n);
    wait_clk(8);
  endtask

  initial begin
    srst = 1'b1;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    cap_exp = {18'h0, STEP_OUTS, ~FOUR_BUILD, 3'(NUM_CTR), 8'h00};
    wait_clk(5);
    srst <= 1'b0;
    rd_chk(8'h10, 32'h0);
    rd_chk(8'hF0, 32'h0);
    rd_reg(8'h00, v);
    check(v & 32'h0000_3F00, cap_exp);
    $display("test reset done");

    // Totalizer up on input 2, then disable held by a high level on 3
    wr_reg(8'h10, 32'h0000_0040);
    pulses(5);
    rd_chk(8'h1C, 32'h5);
    wr_reg(8'h14, 32'h0000_0700);
    lvl3(1'b1);
    pulses(3);
    rd_chk(8'h1C, 32'h5);
    lvl3(1'b0);
    pulses(2);
    rd_chk(8'h1C, 32'h7);
    $display("test count and disable done");

    // Latch on rising edge of input 3 holds while counting goes on
    wr_reg(8'h14, 32'h001F_0000);
    lvl3(1'b1);
    rd_chk(8'h20, 32'h7);
    pulses(1);
    rd_chk(8'h1C, 32'h8);
    rd_chk(8'h20, 32'h7);
    // Late latch takes the count when the strobe goes inactive
    wr_reg(8'h14, 32'h003F_0000);
    lvl3(1'b0);
    rd_chk(8'h20, 32'h8);
    $display("test latch done");

    // Clear on rising edge fires once; preload on falling edge
    wr_reg(8'h14, 32'h0000_001F);
    lvl3(1'b1);
    rd_chk(8'h1C, 32'h0);
    pulses(2);
    rd_chk(8'h1C, 32'h2);
    wr_reg(8'h18, 32'h0000_1234);
    wr_reg(8'h14, 32'h1700_0000);
    lvl3(1'b0);
    rd_chk(8'h1C, 32'h1234);
    // Low-level clear pins the count at zero
    wr_reg(8'h14, 32'h0000_000F);
    wait_clk(4);
    pulses(2);
    rd_chk(8'h1C, 32'h0);
    $display("test clear and preload done");

    // Frequency mode ignores a held preload; no edges reads zero hertz
    wr_reg(8'h10, 32'h0000_0041);
    wr_reg(8'h14, 32'h0700_0000);
    lvl3(1'b1);
    wait_clk(200);
    rd_chk(8'h1C, 32'h0);
    // Steady pulse train: every full window sees six rising edges
    fork
      u_src.pulse(2, 20);
    join_none
    wait_clk(150);
    rd_chk(8'h1C, 32'd6);
    wait fork;
    lvl3(1'b0);
    $display("test frequency done");

    // Width and period: 601 clocks leave 600 counted, three us ticks
    wr_reg(8'h10, 32'h0000_0042);
    u_src.set_lvl(2, 1'b1);
    wait_clk(596);
    u_src.set_lvl(2, 1'b0);
    wait_clk(8);
    rd_chk(8'h1C, 32'd3);
    wr_reg(8'h10, 32'h0000_0043);
    u_src.set_lvl(2, 1'b1);
    wait_clk(591);
    u_src.set_lvl(2, 1'b0);
    u_src.set_lvl(2, 1'b1);
    wait_clk(8);
    rd_chk(8'h1C, 32'd3);
    u_src.set_lvl(2, 1'b0);
    $display("test width and period done");

    // Quadrature on counter 1, inputs 1 and 2, marker on input 3
    wr_reg(8'h10, 32'h0000_0005);
    wr_reg(8'h30, 32'h0000_7124);
    u_src.quad(3, 1'b0);
    wait_clk(8);
    rd_chk(8'h3C, 32'd12);
    u_src.quad(1, 1'b1);
    wait_clk(8);
    rd_chk(8'h3C, 32'd8);
    wr_reg(8'h30, 32'h0000_712C);
    u_src.quad(1, 1'b0);
    wait_clk(8);
    rd_chk(8'h3C, 32'd4);
    lvl3(1'b1);
    rd_reg(8'h00, v);
    check(v & 32'h0000_00FF, 32'h0000_0086);
    rd_chk(8'h3C, 32'h0);
    lvl3(1'b0);
    $display("test quadrature done");
    tally_and_finish();
  end
endmodule // tb_high_speed_counter_unit
`default_nettype wire
